// >>> hw/vepc_regs.svh
// Register offsets, field positions, reset values and timing counts of the pin control block.
`ifndef VEPC_REGS_SVH
`define VEPC_REGS_SVH

`define VEPC_ADDR_W        4
`define VEPC_OFF_MODE      4'h0
`define VEPC_OFF_OUTCFG    4'h1
`define VEPC_OFF_STATUS    4'h2
`define VEPC_OFF_SERADDR   4'h3
`define VEPC_OFF_PIXEL     4'h4
`define VEPC_OFF_SCEVENTS  4'h5
`define VEPC_OFF_LINELEN   4'h6
`define VEPC_OFF_FIELDLEN  4'h7

// Mode register fields.
`define VEPC_MODE_STD      0
`define VEPC_MODE_MASTER   1
`define VEPC_MODE_TMG_LO   2
`define VEPC_MODE_TMG_HI   3
`define VEPC_MODE_WIDE     4
`define VEPC_MODE_SEL_LO   5
`define VEPC_MODE_SEL_HI   6
`define VEPC_MODE_TTX      7
`define VEPC_MODE_RESET    8'h00

// Output configuration fields: output format and per-converter power.
`define VEPC_OUTCFG_FMT_LO 0
`define VEPC_OUTCFG_FMT_HI 1
`define VEPC_OUTCFG_DACB   2
`define VEPC_OUTCFG_DACD   3
`define VEPC_OUTCFG_RESET  8'h04

// Serial address: upper bits fixed, low bit from the address-select pin.
`define VEPC_SERADDR_BASE  7'h6a

// Default master timing: line and line-sync lengths in pixel clocks, field length in lines.
`define VEPC_LINE_LEN      16'h06b4
`define VEPC_FIELD_LEN     16'h0106
`define VEPC_HSYNC_LEN     16'h0080

`endif

// >>> hw/vepc_pkg.sv
// Types shared by the pin control block.
package vepc_pkg;
  typedef enum logic [1:0] {
    VEPC_SC_OFF   = 2'b00,
    VEPC_SC_RESET = 2'b01,
    VEPC_SC_RTC   = 2'b10,
    VEPC_SC_RSVD  = 2'b11
  } vepc_scsel_e;

  typedef enum logic [1:0] {
    VEPC_TM_0 = 2'b00,
    VEPC_TM_1 = 2'b01,
    VEPC_TM_2 = 2'b11,
    VEPC_TM_3 = 2'b10
  } vepc_tmode_e;

  typedef struct packed {
    logic        valid;
    logic [15:0] data;
    logic        wide;
  } vepc_pixel_s;

  typedef struct packed {
    logic hsync;
    logic frame;
  } vepc_sync_s;
endpackage

// >>> hw/vepc_pin_control.sv
// Pin-level control of the video encoder: pixel port, sync pins, subcarrier pin, teletext.
`timescale 1ns/1ps
`include "vepc_regs.svh"

// Function
// - Pixel port takes 8-bit on low lines or 16-bit on all; bit 0 LSB.
// - Line-sync pin driven as timing master, input as timing slave.
// - Frame pin is field in mode 1, vertical sync in mode 2.
// - Pixel inputs are ignored while blanking input is low.
// - Address-select pin sets the serial control address low bit.
// - Reset restores NTSC, slave mode 0, 8-bit, default outputs and converter power.
// - Two mode bits select the subcarrier sync pin function.
// - Rising edge on the pin resets the subcarrier to field 0.
// - Alternatively the pin serves as real-time control input.
// - Teletext request held low when teletext is not selected.
// - Teletext data input reads as high when teletext is not selected.
// - Broadcast 4:2:2 data arrives in parallel interface format at 27 MHz.
// - Configuration is written over a parallel address/data register port.
module vepc_pin_control #(
  parameter int PIX_W = 16  // Pixel bus width.
) (
  input  wire logic                    ref_clk_i,          // Pixel clock.
  input  wire logic                    resetn_i,           // Synchronous reset, active low.
  input  wire logic [`VEPC_ADDR_W-1:0] reg_addr_i,         // Register address.
  input  wire logic [7:0]              reg_wdata_i,        // Register write data.
  input  wire logic                    reg_wr_i,           // Write strobe.
  input  wire logic                    reg_rd_i,           // Read strobe.
  output logic      [7:0]              reg_rdata_o,        // Read data, cycle after strobe.
  input  wire logic [PIX_W-1:0]        pixel_bus_i,        // Pixel data lines.
  input  wire logic                    blank_n_i,          // Blanking control, active low.
  input  wire logic                    hsync_i,            // Line-sync pin input.
  output logic                         hsync_o,            // Line-sync pin output.
  output logic                         hsync_oe_o,         // Line-sync pin drive enable.
  input  wire logic                    frame_i,            // Field/vertical-sync pin input.
  output logic                         frame_o,            // Field/vertical-sync pin output.
  output logic                         frame_oe_o,         // Field/vertical-sync pin drive enable.
  input  wire logic                    addr_low_select_i,  // Serial address low bit select.
  input  wire logic                    subcarrier_sync_i,  // Subcarrier reset or control pin.
  input  wire logic                    teletext_in_i,      // Teletext data pin.
  input  wire logic                    teletext_req_int_i, // Core teletext request.
  output logic                         teletext_request_o, // Teletext request pin.
  output logic                         teletext_bit_o,     // Teletext data to core.
  output vepc_pkg::vepc_pixel_s        pixel_o,            // Sampled pixel to core.
  output vepc_pkg::vepc_sync_s         sync_o,             // Sync seen by the core.
  output logic                         sc_reset_o,         // Subcarrier reset pulse.
  output logic                         rtc_o,              // Real-time control bit.
  output logic      [6:0]              serial_addr_o       // Serial control address.
);

  initial begin
    if (PIX_W != 16) $error("vepc_pin_control: PIX_W must be 16");
  end

  logic [7:0]  mode_reg;
  logic [7:0]  outcfg_reg;
  logic [15:0] line_len_reg;
  logic [15:0] field_len_reg;
  logic [15:0] hcnt_reg;
  logic [15:0] vcnt_reg;
  logic        field_reg;
  logic        sc_prev_reg;
  logic [7:0]  sc_events_reg;
  logic [7:0]  rdata_reg;
  logic [7:0]  rdata_next;
  vepc_pkg::vepc_pixel_s pixel_reg;
  vepc_pkg::vepc_sync_s  sync_reg;
  logic        sc_reset_reg;
  logic        rtc_reg;
  logic        hsync_reg;
  logic        frame_reg;

  wire logic                  is_master = mode_reg[`VEPC_MODE_MASTER];
  wire logic                  is_wide   = mode_reg[`VEPC_MODE_WIDE];
  wire logic                  ttx_on    = mode_reg[`VEPC_MODE_TTX];
  wire vepc_pkg::vepc_tmode_e tmode =
    vepc_pkg::vepc_tmode_e'(mode_reg[`VEPC_MODE_TMG_HI:`VEPC_MODE_TMG_LO]);
  wire vepc_pkg::vepc_scsel_e scsel =
    vepc_pkg::vepc_scsel_e'({mode_reg[`VEPC_MODE_SEL_HI], mode_reg[`VEPC_MODE_SEL_LO]});
  wire logic line_end  = (hcnt_reg == line_len_reg - 16'h0001);
  wire logic field_end = line_end && (vcnt_reg == field_len_reg - 16'h0001);
  wire logic sc_rise   = subcarrier_sync_i && !sc_prev_reg;
  wire logic wr_mode   = reg_wr_i && (reg_addr_i == `VEPC_OFF_MODE);
  wire logic wr_outcfg = reg_wr_i && (reg_addr_i == `VEPC_OFF_OUTCFG);
  wire logic wr_line   = reg_wr_i && (reg_addr_i == `VEPC_OFF_LINELEN);
  wire logic wr_field  = reg_wr_i && (reg_addr_i == `VEPC_OFF_FIELDLEN);
  wire logic wr_events = reg_wr_i && (reg_addr_i == `VEPC_OFF_SCEVENTS);
  wire logic sc_hit    = (scsel == vepc_pkg::VEPC_SC_RESET) && sc_rise;
  wire logic [6:0] ser_base = `VEPC_SERADDR_BASE;

  assign serial_addr_o = {ser_base[6:1], addr_low_select_i};

  assign hsync_oe_o = is_master;
  assign hsync_o    = hsync_reg;
  assign frame_oe_o = is_master;
  assign frame_o    = frame_reg;

  assign teletext_request_o = ttx_on && teletext_req_int_i;
  assign teletext_bit_o     = ttx_on ? teletext_in_i : 1'b1;

  assign pixel_o     = pixel_reg;
  assign sync_o      = sync_reg;
  assign sc_reset_o  = sc_reset_reg;
  assign rtc_o       = rtc_reg;
  assign reg_rdata_o = rdata_reg;

  // Register file; reset gives NTSC, slave mode 0, 8-bit input and default outputs.
  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      mode_reg      <= `VEPC_MODE_RESET;
      outcfg_reg    <= `VEPC_OUTCFG_RESET;
      line_len_reg  <= `VEPC_LINE_LEN;
      field_len_reg <= `VEPC_FIELD_LEN;
    end else begin
      if (wr_mode)   mode_reg      <= reg_wdata_i;
      if (wr_outcfg) outcfg_reg    <= reg_wdata_i;
      if (wr_line)   line_len_reg  <= {line_len_reg[7:0], reg_wdata_i};
      if (wr_field)  field_len_reg <= {field_len_reg[7:0], reg_wdata_i};
    end
  end

  // Master timing generator; a slave resynchronises it from the incoming line sync.
  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      hcnt_reg  <= 16'h0000;
      vcnt_reg  <= 16'h0000;
      field_reg <= 1'b0;
    end else if (!is_master && hsync_i == 1'b0) begin
      hcnt_reg <= 16'h0000;
    end else if (line_end) begin
      hcnt_reg <= 16'h0000;
      vcnt_reg <= field_end ? 16'h0000 : vcnt_reg + 16'h0001;
      if (field_end) field_reg <= !field_reg;
    end else begin
      hcnt_reg <= hcnt_reg + 16'h0001;
    end
  end

  // Sync pin drive, active low, registered so the pins do not glitch.
  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      hsync_reg <= 1'b1;
      frame_reg <= 1'b1;
    end else begin
      hsync_reg <= !(hcnt_reg < `VEPC_HSYNC_LEN);
      frame_reg <= (tmode == vepc_pkg::VEPC_TM_2) ? !(vcnt_reg == 16'h0000) : field_reg;
    end
  end

  // Pixel and control sampling on the rising clock edge.
  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      pixel_reg <= '0;
      sync_reg  <= '{hsync: 1'b1, frame: 1'b1};
    end else begin
      sync_reg.hsync <= is_master ? hsync_reg : hsync_i;
      sync_reg.frame <= is_master ? frame_reg : frame_i;
      pixel_reg.valid <= blank_n_i;
      pixel_reg.wide  <= is_wide;
      if (blank_n_i) begin
        pixel_reg.data <= is_wide ? pixel_bus_i : {8'h00, pixel_bus_i[7:0]};
      end
    end
  end

  // Subcarrier pin: reset pulse on rising edge, or a sampled control bit.
  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      sc_prev_reg   <= 1'b0;
      sc_reset_reg  <= 1'b0;
      rtc_reg       <= 1'b0;
      sc_events_reg <= 8'h00;
    end else begin
      sc_prev_reg  <= subcarrier_sync_i;
      sc_reset_reg <= sc_hit;
      if (scsel == vepc_pkg::VEPC_SC_RTC) rtc_reg <= subcarrier_sync_i;
      // A reset arriving with the clear write still counts.
      if (sc_hit) sc_events_reg <= (wr_events ? 8'h00 : sc_events_reg) + 8'h01;
      else if (wr_events) sc_events_reg <= 8'h00;
    end
  end

  // Read mux; unmapped addresses read zero.
  always_comb begin
    rdata_next = 8'h00;
    unique case (reg_addr_i)
      `VEPC_OFF_MODE:     rdata_next = mode_reg;
      `VEPC_OFF_OUTCFG:   rdata_next = outcfg_reg;
      `VEPC_OFF_STATUS:   rdata_next = {4'h0, field_reg, sc_prev_reg, hsync_reg, frame_reg};
      `VEPC_OFF_SERADDR:  rdata_next = {1'b0, serial_addr_o};
      `VEPC_OFF_PIXEL:    rdata_next = pixel_reg.data[7:0];
      `VEPC_OFF_SCEVENTS: rdata_next = sc_events_reg;
      `VEPC_OFF_LINELEN:  rdata_next = line_len_reg[7:0];
      `VEPC_OFF_FIELDLEN: rdata_next = field_len_reg[7:0];
      default:            rdata_next = 8'h00;
    endcase
  end

  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) rdata_reg <= 8'h00;
    else           rdata_reg <= reg_rd_i ? rdata_next : 8'h00;
  end

endmodule // vepc_pin_control

// >>> bench/vepc_pin_control_assertions.sv
// Port-level checker for the pin control block.
`timescale 1ns/1ps
`include "vepc_regs.svh"
module vepc_checker (
  input wire logic                    ref_clk_i,          // Clock.
  input wire logic                    resetn_i,           // Reset.
  input wire logic [`VEPC_ADDR_W-1:0] reg_addr_i,         // Address.
  input wire logic [7:0]              reg_wdata_i,        // Write data.
  input wire logic                    reg_wr_i,           // Write.
  input wire logic                    reg_rd_i,           // Read.
  input wire logic [7:0]              reg_rdata_o,        // Read data.
  input wire logic [15:0]             pixel_bus_i,        // Pixels.
  input wire logic                    blank_n_i,          // Blank.
  input wire logic                    hsync_oe_o,         // Line drive.
  input wire logic                    frame_oe_o,         // Frame drive.
  input wire logic                    addr_low_select_i,  // Addr pin.
  input wire logic                    subcarrier_sync_i,  // Sync pin.
  input wire logic                    teletext_in_i,      // Ttx in.
  input wire logic                    teletext_req_int_i, // Ttx core req.
  input wire logic                    teletext_request_o, // Ttx req.
  input wire logic                    teletext_bit_o,     // Ttx bit.
  input wire vepc_pkg::vepc_pixel_s   pixel_o,            // Pixel.
  input wire logic                    sc_reset_o,         // Sc pulse.
  input wire logic                    rtc_o,              // Rtc bit.
  input wire logic [6:0]              serial_addr_o       // Serial addr.
);
  logic [7:0]  mode_sh;
  logic [15:0] mask_q;
  wire logic   sel_rst = mode_sh[6:5] == 2'h1;
  wire logic   sel_rtc = mode_sh[6:5] == 2'h2;
  // Shadow of the mode register, so checks need no internal probes.
  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i)
      mode_sh <= 8'h00;
    else if (reg_wr_i && reg_addr_i == `VEPC_OFF_MODE)
      mode_sh <= reg_wdata_i;
  end
  always_ff @(posedge ref_clk_i) mask_q <= mode_sh[4] ? 16'hffff : 16'h00ff;
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!resetn_i);
  addr_low_a: assert property (serial_addr_o == {6'h35, addr_low_select_i})
    else $error("serial address wrong");
  drive_en_a: assert property (hsync_oe_o == mode_sh[1] && frame_oe_o == mode_sh[1])
    else $error("sync drive enable wrong");
  ttx_req_a: assert property (teletext_request_o == (mode_sh[7] & teletext_req_int_i))
    else $error("teletext request wrong");
  ttx_bit_a: assert property (teletext_bit_o == (mode_sh[7] ? teletext_in_i : 1'b1))
    else $error("teletext bit wrong");
  rd_mode_a: assert property (reg_rd_i && reg_addr_i == `VEPC_OFF_MODE |=>
    reg_rdata_o == $past(mode_sh)) else $error("mode readback wrong");
  pix_take_a: assert property (blank_n_i |=> pixel_o.valid &&
    pixel_o.data == ($past(pixel_bus_i) & mask_q)) else $error("pixel not taken");
  pix_ignore_a: assert property (!blank_n_i |=> !pixel_o.valid && $stable(pixel_o.data))
    else $error("blanked pixel taken");
  sc_pulse_a: assert property (sel_rst && $rose(subcarrier_sync_i) |-> ##[1:2] sc_reset_o)
    else $error("subcarrier reset missing");
  sc_sel_a: assert property (!sel_rst |=> !sc_reset_o)
    else $error("subcarrier reset in wrong mode");
  rtc_follow_a: assert property (sel_rtc |=> rtc_o == $past(subcarrier_sync_i))
    else $error("control bit wrong");
endmodule // vepc_checker
bind vepc_pin_control vepc_checker vepc_checker_i (.ref_clk_i(ref_clk_i), .resetn_i(resetn_i),
  .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
  .reg_rdata_o(reg_rdata_o), .pixel_bus_i(pixel_bus_i), .blank_n_i(blank_n_i),
  .hsync_oe_o(hsync_oe_o), .frame_oe_o(frame_oe_o), .addr_low_select_i(addr_low_select_i),
  .subcarrier_sync_i(subcarrier_sync_i), .teletext_in_i(teletext_in_i),
  .teletext_req_int_i(teletext_req_int_i), .teletext_request_o(teletext_request_o),
  .teletext_bit_o(teletext_bit_o), .pixel_o(pixel_o), .sc_reset_o(sc_reset_o), .rtc_o(rtc_o),
  .serial_addr_o(serial_addr_o));

// >>> bench/vepc_pix_src.sv
// Pixel source model on the far side of the pixel port.
`timescale 1ns/1ps
module vepc_pix_src (
  input  wire logic        ref_clk_i,   // Pixel clock.
  input  wire logic [15:0] px_i,        // Pixel to send.
  input  wire logic        bl_i,        // Send as active.
  input  wire logic        hs_i,        // Line-sync level.
  input  wire logic        fr_i,        // Frame level.
  input  wire logic        sc_i,        // Subcarrier pin level.
  output logic      [15:0] pixel_bus_o, // Pixel lines.
  output logic             blank_n_o,   // Blank pin.
  output logic             hsync_o,     // Line-sync pin.
  output logic             frame_o,     // Frame pin.
  output logic             sc_o         // Subcarrier pin.
);
  initial {pixel_bus_o, blank_n_o, hsync_o, frame_o, sc_o} = '0;
  always @(posedge ref_clk_i) begin
    {blank_n_o, hsync_o, frame_o, sc_o} <= {bl_i, hs_i, fr_i, sc_i};
    pixel_bus_o <= bl_i ? px_i : ~pixel_bus_o;
  end
endmodule // vepc_pix_src

// >>> bench/vepc_pin_control_tb.sv
// Self-checking bench for the pin control block.
`timescale 1ns/1ps
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin error_cnt++; \
  $display("wrong value %s exp %h got %h", n, e, g); end end
module vepc_pin_control_tb;
  logic        clk, rstn, wr, rd, addr_low_select, tt_in, tt_req, c_bl, c_hs, c_fr, c_sc, p;
  logic [3:0]  addr;
  logic [7:0]  wdata, rdata, rv;
  logic [15:0] c_px, px;
  logic        bl_n, hs, fr, sc, hs_o, hs_oe, fr_oe, ttr, ttb, sc_rst, rtc, fr_o;
  vepc_pkg::vepc_sync_s syn;
  logic [6:0]  saddr;
  vepc_pkg::vepc_pixel_s pix;
  int          error_cnt, cmp_count, n, f1, f2, lo;
  vepc_pin_control vepc_pin_control_i (.ref_clk_i(clk), .resetn_i(rstn), .reg_addr_i(addr),
    .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata), .pixel_bus_i(px),
    .blank_n_i(bl_n), .hsync_i(hs), .hsync_o(hs_o), .hsync_oe_o(hs_oe), .frame_i(fr),
    .frame_o(fr_o), .frame_oe_o(fr_oe), .addr_low_select_i(addr_low_select), .subcarrier_sync_i(sc),
    .teletext_in_i(tt_in), .teletext_req_int_i(tt_req), .teletext_request_o(ttr),
    .teletext_bit_o(ttb), .pixel_o(pix), .sync_o(syn), .sc_reset_o(sc_rst), .rtc_o(rtc),
    .serial_addr_o(saddr));
  vepc_pix_src vepc_pix_src_i (.ref_clk_i(clk), .px_i(c_px), .bl_i(c_bl), .hs_i(c_hs),
    .fr_i(c_fr), .sc_i(c_sc), .pixel_bus_o(px), .blank_n_o(bl_n), .hsync_o(hs), .frame_o(fr),
    .sc_o(sc));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    {wr, addr, wdata} <= {1'b1, a, d};
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [3:0] a);
    @(posedge clk);
    {rd, addr} <= {1'b1, a};
    @(posedge clk);
    rd <= 1'b0;
    #1 rv = rdata;
  endtask
  // Source sends one beat; returns once the block has sampled it.
  task automatic drv(input logic [15:0] d, input logic b, h, f, s);
    @(posedge clk);
    {c_px, c_bl, c_hs, c_fr, c_sc} <= {d, b, h, f, s};
    repeat (2) @(posedge clk);
    #1;
  endtask
  task automatic t_regs();
    rd_reg(4'h0); `CHK("mode", 8'h00, rv);
    rd_reg(4'h1); `CHK("outcfg", 8'h04, rv);
    rd_reg(4'h8); `CHK("unmapped", 8'h00, rv);
    `CHK("drive en", 2'h0, {hs_oe, fr_oe});
    for (n = 0; n < 2; n++) begin
      @(posedge clk);
      addr_low_select <= n[0];
      @(posedge clk);
      #1 `CHK("serial addr", {6'h35, n[0]}, saddr);
    end
  endtask
  task automatic t_pixel();
    drv(16'h1234, 1'b1, 1'b0, 1'b1, 1'b0); `CHK("px8", 16'h0034, pix.data);
    wr_reg(4'h0, 8'h10);
    drv(16'ha5c3, 1'b1, 1'b1, 1'b0, 1'b0); `CHK("px16", 16'ha5c3, pix.data);
    drv(16'h5a5a, 1'b0, 1'b1, 1'b1, 1'b0); `CHK("blank", {1'b0, 16'ha5c3, 1'b1}, pix);
    wr_reg(4'h0, 8'h00);
  endtask
  task automatic t_subcarrier();
    wr_reg(4'h0, 8'h20);
    wr_reg(4'h5, 8'h00);
    drv(16'h0000, 1'b1, 1'b1, 1'b1, 1'b1);
    for (n = 0; n < 4 && sc_rst !== 1'b1; n++) @(posedge clk) #1;
    `CHK("sc pulse", 1'b1, sc_rst);
    rd_reg(4'h5); `CHK("sc events", 8'h01, rv);
    wr_reg(4'h0, 8'h40);
    drv(16'h0000, 1'b1, 1'b1, 1'b1, 1'b0); `CHK("rtc", 1'b0, rtc);
    drv(16'h0000, 1'b1, 1'b1, 1'b1, 1'b1); `CHK("rtc", 1'b1, rtc);
    @(posedge clk) #1 `CHK("no pulse", 1'b0, sc_rst);
  endtask
  task automatic t_teletext();
    {tt_req, tt_in} <= 2'h2;
    @(posedge clk) #1 `CHK("ttx off", 2'h1, {ttr, ttb});
    wr_reg(4'h0, 8'h80);
    #1 `CHK("ttx on", 2'h2, {ttr, ttb});
  endtask
  task automatic t_master();
    wr_reg(4'h0, 8'h02);
    #1 `CHK("drive en", 2'h3, {hs_oe, fr_oe});
    {f1, f2, lo} = {-32'sd1, -32'sd1, 32'sd0};
    for (n = 0; n < 4000; n++) begin
      p = hs_o;
      @(posedge clk) #1;
      if (p === 1'b1 && hs_o === 1'b0) begin
        if (f1 < 0) f1 = n; else if (f2 < 0) f2 = n;
      end
      if (f1 >= 0 && f2 < 0 && hs_o === 1'b0) lo++;
    end
    `CHK("sync low", 128, lo);
    `CHK("line len", 1716, f2 - f1);
    if (f2 < 0) conclude();
  endtask
  // Short lines and fields are loaded while the slave holds the line counter at zero.
  task automatic t_frame();
    wr_reg(4'h0, 8'h00);
    drv(16'h0000, 1'b1, 1'b0, 1'b1, 1'b0);
    wr_reg(4'h6, 8'h00);
    wr_reg(4'h6, 8'h10);
    wr_reg(4'h7, 8'h00);
    wr_reg(4'h7, 8'h10);
    rd_reg(4'h6); `CHK("line len reg", 8'h10, rv);
    wr_reg(4'h0, 8'h0e);
    {f1, f2} = {32'sd0, 32'sd0};
    for (n = 0; n < 513; n++) begin
      @(posedge clk) #1;
      if (n < 512 && fr_o === 1'b0) f1++;
      if (n > 0 && syn.frame === 1'b0) f2++;
    end
    `CHK("vsync low", 32, f1);
    `CHK("core vsync", 32, f2);
  endtask
  task automatic conclude();
    if (error_cnt == 0 && cmp_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  initial begin
    {wr, rd, addr_low_select, tt_in, tt_req, c_bl, c_sc, addr, wdata, c_px} = '0;
    {c_hs, c_fr, rstn} = 3'h6;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    t_regs();
    t_pixel();
    t_subcarrier();
    t_teletext();
    t_master();
    t_frame();
    conclude();
  end
endmodule // vepc_pin_control_tb
